// ===== logic/tcis_core.sv
// Notes on behaviour
// - Enable-clear write ones drop enables.
// - Enable-set write ones raise enables.
// - Both enable registers read shared bits.
// - Channels 5:4, sync 3, error 1, wrap 0.
// - Reserved bits read zero; software writes zero.
// - Channel flag sets on match or capture.
// - Channel flag requests only when enabled.
// - Writing one clears a channel flag.
// - Capture register read clears channel flag in capture mode.
// - Sync ready on busy fall, not enable.
// - Writing one clears sync ready flag.
// - Error on capture while flag set.
// - Writing one clears error flag.
// - Wrap flag sets cycle after overflow.
// - Writing one clears wrap flag.
// - Sync busy tracks synchronization in progress.
// - Cascade slave when partner is 32-bit master.
// - Stopped on disable, stop, single-run wrap.
// - Eight-bit counter value, reset zero, synchronized.
// - Single run stops at next wrap.
`default_nettype none
module tcis_core
  import tcis_pkg::*;
#(
  parameter int SYNC_CYCLES = TCIS_SYNC_CYCLES
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [1:0] channelMatch,
  input wire logic [1:0] channelCapture,
  input wire logic [7:0] capture0,
  input wire logic [7:0] capture1,
  input wire logic partnerMaster32,
  output logic irqRequest
);
  import tcis_pkg::*;

  // ==========================================================================
  // State
  logic [7:0] irqEnable;
  logic [7:0] irqFlags;
  logic [7:0] count;
  logic [7:0] control;
  logic stopped;
  logic [1:0] syncCnt;
  logic sync_in_progress;
  logic syncBusyPrev;
  logic syncFromEnable;
  logic slaveMeta;
  logic slaveSync;
  logic [7:0] next_rdata;

  // ==========================================================================
  // Elaboration checks
  // The busy window counter is two bits wide, and the busy check allows at
  // most three cycles, so longer windows are refused here.
  if (SYNC_CYCLES < 1 || SYNC_CYCLES > 3) begin : g_bad_sync
    $error("sync window must be one to three cycles");
  end

  // ==========================================================================
  // Decode helpers
  // Used only in procedural code and checks: it reads the bus directly.
  function automatic logic isWrite(input logic [7:0] a);
    isWrite = regWrite && regAddr == a;
  endfunction : isWrite

  // Pure form for continuous assignments, which only wake on their arguments.
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
      input logic [7:0] a);
    hit = strobe && addr == a;
  endfunction : hit

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = a inside {TCIS_OFF_IRQ_ENABLE_CLEAR, TCIS_OFF_IRQ_ENABLE_SET,
        TCIS_OFF_IRQ_FLAGS, TCIS_OFF_UNIT_STATUS, TCIS_OFF_COUNTER_VALUE,
        TCIS_OFF_CONTROL, TCIS_OFF_CAPTURE0, TCIS_OFF_CAPTURE1};
  endfunction : isMapped

  wire logic enabled = control[TCIS_CTL_ENABLE];
  wire logic overflow = enabled && !stopped && count == 8'hff;
  wire logic [1:0] captureMode = {control[TCIS_CTL_CAPT1], control[TCIS_CTL_CAPT0]};
  wire logic [1:0] chanEvent = (channelMatch & ~captureMode) | (channelCapture & captureMode);
  wire logic [1:0] capRead = captureMode &
      {hit(regRead, regAddr, TCIS_OFF_CAPTURE1), hit(regRead, regAddr, TCIS_OFF_CAPTURE0)};
  wire logic syncStart = hit(regWrite, regAddr, TCIS_OFF_COUNTER_VALUE)
      || hit(regWrite, regAddr, TCIS_OFF_CONTROL)
      || hit(regRead, regAddr, TCIS_OFF_COUNTER_VALUE);
  wire logic syncFall = syncBusyPrev && !sync_in_progress;
  // A second capture onto a raised channel flag has nowhere to be stored.
  wire logic errEvent = |(channelCapture & captureMode &
      {irqFlags[TCIS_BIT_CH1], irqFlags[TCIS_BIT_CH0]});
  // Enabling the unit also opens a busy window, but its end must not look like news.
  wire logic syncReady = syncFall && !syncFromEnable;

  // ==========================================================================
  // Interrupt enables
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irqEnable <= TCIS_RST_ENABLE;
    end else if (clkEn) begin
      if (isWrite(TCIS_OFF_IRQ_ENABLE_CLEAR)) begin
        irqEnable <= irqEnable & ~(regWdata & TCIS_IRQ_MASK);
      end else if (isWrite(TCIS_OFF_IRQ_ENABLE_SET)) begin
        irqEnable <= irqEnable | (regWdata & TCIS_IRQ_MASK);
      end
    end
  end

  // ==========================================================================
  // Flags: a set in the same cycle as a write-one clear wins.
  always_ff @(posedge mclk) begin
    logic [7:0] setBits;
    logic [7:0] clrBits;
    setBits = 8'h00;
    clrBits = 8'h00;
    if (!resetn) begin
      irqFlags <= TCIS_RST_FLAGS;
    end else if (clkEn) begin
      setBits[TCIS_BIT_CH0] = chanEvent[0];
      setBits[TCIS_BIT_CH1] = chanEvent[1];
      setBits[TCIS_BIT_ERROR] = errEvent;
      setBits[TCIS_BIT_WRAP] = overflow;
      setBits[TCIS_BIT_SYNC_READY] = syncReady;
      if (isWrite(TCIS_OFF_IRQ_FLAGS)) begin
        clrBits = regWdata & TCIS_IRQ_MASK;
      end
      clrBits[TCIS_BIT_CH0] = clrBits[TCIS_BIT_CH0] | capRead[0];
      clrBits[TCIS_BIT_CH1] = clrBits[TCIS_BIT_CH1] | capRead[1];
      irqFlags <= ((irqFlags & ~clrBits) | setBits) & TCIS_IRQ_MASK;
    end
  end

  // Combinational so the request drops in the same cycle a flag clears.
  assign irqRequest = |(irqFlags & irqEnable);

  // ==========================================================================
  // Control, counter and run state
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      control <= TCIS_RST_CONTROL;
    end else if (clkEn && isWrite(TCIS_OFF_CONTROL)) begin
      control <= regWdata & TCIS_CTL_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stopped <= TCIS_RST_STATUS[TCIS_BIT_STOPPED];
    end else if (clkEn) begin
      if (isWrite(TCIS_OFF_CONTROL)) begin
        stopped <= !regWdata[TCIS_CTL_ENABLE] || regWdata[TCIS_CTL_STOP];
      end else if (overflow && control[TCIS_CTL_SINGLE_RUN]) begin
        stopped <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count <= TCIS_RST_COUNT;
    end else if (clkEn) begin
      if (isWrite(TCIS_OFF_COUNTER_VALUE)) begin
        count <= regWdata;
      end else if (enabled && !stopped) begin
        count <= count + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Synchronization busy model: a fixed short busy window per counter access or control write.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      syncCnt <= 2'h0;
      sync_in_progress <= 1'b0;
      syncBusyPrev <= 1'b0;
      syncFromEnable <= 1'b0;
    end else if (clkEn) begin
      syncBusyPrev <= sync_in_progress;
      if (syncStart) begin
        syncCnt <= 2'(SYNC_CYCLES);
        sync_in_progress <= 1'b1;
        syncFromEnable <= isWrite(TCIS_OFF_CONTROL) && regWdata[TCIS_CTL_ENABLE] && !enabled;
      end else if (syncCnt != 2'h0) begin
        syncCnt <= syncCnt - 2'h1;
        sync_in_progress <= syncCnt != 2'h1;
      end
    end
  end

  // The partner strap arrives from another unit, so it is synchronised.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      slaveMeta <= 1'b0;
      slaveSync <= 1'b0;
    end else if (clkEn) begin
      slaveMeta <= partnerMaster32;
      slaveSync <= slaveMeta;
    end
  end

  // ==========================================================================
  // Register read port
  always_comb begin
    next_rdata = 8'h00;
    unique case (regAddr)
      TCIS_OFF_IRQ_ENABLE_CLEAR, TCIS_OFF_IRQ_ENABLE_SET: next_rdata = irqEnable;
      TCIS_OFF_IRQ_FLAGS: next_rdata = irqFlags;
      TCIS_OFF_UNIT_STATUS: begin
        next_rdata[TCIS_BIT_SYNC_BUSY] = sync_in_progress;
        next_rdata[TCIS_BIT_CASCADE_SLAVE] = slaveSync;
        next_rdata[TCIS_BIT_STOPPED] = stopped;
      end
      TCIS_OFF_COUNTER_VALUE: next_rdata = count;
      TCIS_OFF_CONTROL: next_rdata = {control[7:3], stopped, control[1:0]} & TCIS_CTL_MASK;
      TCIS_OFF_CAPTURE0: next_rdata = capture0;
      TCIS_OFF_CAPTURE1: next_rdata = capture1;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= regRead ? next_rdata : 8'h00;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn || !clkEn);

  en_clear_a: assert property (isWrite(TCIS_OFF_IRQ_ENABLE_CLEAR) |=>
      (irqEnable & $past(regWdata) & TCIS_IRQ_MASK) == 8'h00) else $error("enable not cleared");
  en_set_a: assert property (isWrite(TCIS_OFF_IRQ_ENABLE_SET) |=>
      (irqEnable & $past(regWdata) & TCIS_IRQ_MASK) == ($past(regWdata) & TCIS_IRQ_MASK))
      else $error("enable not set");
  reserved_zero_a: assert property ((irqFlags & ~TCIS_IRQ_MASK) == 8'h00 &&
      (irqEnable & ~TCIS_IRQ_MASK) == 8'h00) else $error("reserved bit set");
  chan_set_a: assert property (chanEvent[0] |=> irqFlags[TCIS_BIT_CH0])
      else $error("channel flag missed");
  irq_gate_a: assert property (irqRequest == |(irqFlags & irqEnable))
      else $error("request mismatch");
  err_set_a: assert property (channelCapture[1] && captureMode[1] && irqFlags[TCIS_BIT_CH1]
      |=> irqFlags[TCIS_BIT_ERROR]) else $error("error flag missed");
  wrap_set_a: assert property (overflow |=> irqFlags[TCIS_BIT_WRAP])
      else $error("wrap flag missed");
  single_stop_a: assert property (overflow && control[TCIS_CTL_SINGLE_RUN]
      && !isWrite(TCIS_OFF_CONTROL) |=> stopped ##1 stopped) else $error("single run kept on");
  sync_busy_a: assert property ($rose(sync_in_progress) |-> ##[1:3] !sync_in_progress)
      else $error("sync busy stuck");
  flag_clear_a: assert property (isWrite(TCIS_OFF_IRQ_FLAGS) && regWdata[TCIS_BIT_WRAP]
      && !overflow |=> !irqFlags[TCIS_BIT_WRAP]) else $error("wrap not cleared");

  wrap_irq_c: cover property (irqEnable[TCIS_BIT_WRAP] && overflow ##1 irqRequest);
  err_c: cover property ($rose(irqFlags[TCIS_BIT_ERROR]));
  sync_rdy_c: cover property ($rose(irqFlags[TCIS_BIT_SYNC_READY]));
  cap_read_c: cover property (hit(regRead, regAddr, TCIS_OFF_CAPTURE0) && captureMode[0]);
  single_stop_c: cover property ($rose(stopped));

  // ==========================================================================
  // Enable paths: a zero bit in a set or clear write leaves its enable alone
  clr_keep_a: assert property (isWrite(TCIS_OFF_IRQ_ENABLE_CLEAR) |=>
      (irqEnable & ~$past(regWdata)) == ($past(irqEnable) & ~$past(regWdata)))
      else $error("enable lost on clear write");
  set_keep_a: assert property (isWrite(TCIS_OFF_IRQ_ENABLE_SET) |=>
      (irqEnable & ~$past(regWdata)) == ($past(irqEnable) & ~$past(regWdata)))
      else $error("enable gained on set write");
  rd_enable_a: assert property (hit(regRead, regAddr, TCIS_OFF_IRQ_ENABLE_SET)
      || hit(regRead, regAddr, TCIS_OFF_IRQ_ENABLE_CLEAR) |=> regRdata == $past(irqEnable))
      else $error("enable read differs");

  // ==========================================================================
  // Channel flags
  chan1_set_a: assert property (chanEvent[1] |=> irqFlags[TCIS_BIT_CH1])
      else $error("channel one flag missed");
  irq_ch1_a: assert property ($past(clkEn) && $past(chanEvent[1])
      && irqEnable[TCIS_BIT_CH1] |-> irqRequest)
      else $error("channel request missed");
  chan_clear_a: assert property (isWrite(TCIS_OFF_IRQ_FLAGS)
      && regWdata[TCIS_BIT_CH1] && !chanEvent[1] |=> !irqFlags[TCIS_BIT_CH1])
      else $error("channel flag not cleared");
  chan_keep_a: assert property (isWrite(TCIS_OFF_IRQ_FLAGS)
      && !regWdata[TCIS_BIT_CH1] && irqFlags[TCIS_BIT_CH1] |=> irqFlags[TCIS_BIT_CH1])
      else $error("channel flag lost on zero write");
  cap_clear_a: assert property (capRead[0] && !chanEvent[0]
      |=> !irqFlags[TCIS_BIT_CH0])
      else $error("capture read kept flag");

  // ==========================================================================
  // Sync and error flags
  sync_rdy_a: assert property ($fell(sync_in_progress) && !syncFromEnable
      |=> irqFlags[TCIS_BIT_SYNC_READY])
      else $error("sync ready missed");
  sync_clear_a: assert property (isWrite(TCIS_OFF_IRQ_FLAGS)
      && regWdata[TCIS_BIT_SYNC_READY] && !syncReady |=> !irqFlags[TCIS_BIT_SYNC_READY])
      else $error("sync ready not cleared");
  err0_set_a: assert property (channelCapture[0] && captureMode[0]
      && irqFlags[TCIS_BIT_CH0] |=> irqFlags[TCIS_BIT_ERROR])
      else $error("channel zero overrun missed");
  err_clear_a: assert property (isWrite(TCIS_OFF_IRQ_FLAGS)
      && regWdata[TCIS_BIT_ERROR] && !errEvent |=> !irqFlags[TCIS_BIT_ERROR])
      else $error("error flag not cleared");

  // ==========================================================================
  // Status, counter and read port
  stop_write_a: assert property (isWrite(TCIS_OFF_CONTROL)
      && !regWdata[TCIS_CTL_ENABLE] |=> stopped)
      else $error("disabled unit not stopped");
  count_write_a: assert property (isWrite(TCIS_OFF_COUNTER_VALUE)
      |=> count == $past(regWdata))
      else $error("count write lost");
  slave_rise_a: assert property ($rose(slaveSync) |-> $past(partnerMaster32, 2))
      else $error("slave status without partner");
  rd_unmapped_a: assert property (regRead && !isMapped(regAddr)
      |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
  rd_status_a: assert property (hit(regRead, regAddr, TCIS_OFF_UNIT_STATUS)
      |=> (regRdata & 8'h67) == 8'h00)
      else $error("status reserved bit set");
endmodule : tcis_core
`default_nettype wire

// ===== shared/tcis_pkg.sv
`default_nettype none
package tcis_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] TCIS_OFF_IRQ_ENABLE_CLEAR = 8'h0c;
  localparam logic [7:0] TCIS_OFF_IRQ_ENABLE_SET = 8'h0d;
  localparam logic [7:0] TCIS_OFF_IRQ_FLAGS = 8'h0e;
  localparam logic [7:0] TCIS_OFF_UNIT_STATUS = 8'h0f;
  localparam logic [7:0] TCIS_OFF_COUNTER_VALUE = 8'h10;
  localparam logic [7:0] TCIS_OFF_CONTROL = 8'h11;
  localparam logic [7:0] TCIS_OFF_CAPTURE0 = 8'h18;
  localparam logic [7:0] TCIS_OFF_CAPTURE1 = 8'h19;
  // ==========================================================================
  // Bit positions in enable and flag registers
  localparam int TCIS_BIT_WRAP = 0;
  localparam int TCIS_BIT_ERROR = 1;
  localparam int TCIS_BIT_SYNC_READY = 3;
  localparam int TCIS_BIT_CH0 = 4;
  localparam int TCIS_BIT_CH1 = 5;
  localparam logic [7:0] TCIS_IRQ_MASK = 8'h3b;
  // ==========================================================================
  // Status bit positions
  localparam int TCIS_BIT_STOPPED = 3;
  localparam int TCIS_BIT_CASCADE_SLAVE = 4;
  localparam int TCIS_BIT_SYNC_BUSY = 7;
  // ==========================================================================
  // Control register (own): bit0 enable, bit1 single run, bit2 stop command,
  // bits 5:4 capture mode for channels 0 and 1.
  localparam int TCIS_CTL_ENABLE = 0;
  localparam int TCIS_CTL_SINGLE_RUN = 1;
  localparam int TCIS_CTL_STOP = 2;
  localparam int TCIS_CTL_CAPT0 = 4;
  localparam int TCIS_CTL_CAPT1 = 5;
  localparam logic [7:0] TCIS_CTL_MASK = 8'h33;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] TCIS_RST_ENABLE = 8'h00;
  localparam logic [7:0] TCIS_RST_FLAGS = 8'h00;
  localparam logic [7:0] TCIS_RST_STATUS = 8'h08;
  localparam logic [7:0] TCIS_RST_COUNT = 8'h00;
  localparam logic [7:0] TCIS_RST_CONTROL = 8'h00;
  localparam int TCIS_SYNC_CYCLES = 2;
endpackage : tcis_pkg
`default_nettype wire

// ===== tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tcis_pkg::*;
  logic mclk, resetn, clkEn, regWrite, regRead, partnerMaster32, irqRequest;
  logic [7:0] regAddr, regWdata, regRdata, capture0, capture1, rd;
  logic [1:0] channelMatch, channelCapture;
  int n_fail, checks;
  tcis_core dut_u (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .channelMatch(channelMatch), .channelCapture(channelCapture), .capture0(capture0),
    .capture1(capture1), .partnerMaster32(partnerMaster32), .irqRequest(irqRequest));
  // ==========================================================================
  // Bus and check helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr
  // The read data stand only in the cycle after the strobe, so sample it there.
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    rd = regRdata;
  endtask : rdr
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // Scenarios
  // Reading the counter opens a busy window, whose end raises sync ready.
  task automatic t_reset;
    rdr(TCIS_OFF_IRQ_ENABLE_CLEAR);
    chk(rd, 8'h00);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h00);
    rdr(TCIS_OFF_UNIT_STATUS);
    chk(rd, 8'h08);
    rdr(TCIS_OFF_COUNTER_VALUE);
    chk(rd, 8'h00);
    rdr(8'h30);
    chk(rd, 8'h00);
    idle(4);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h08);
    wr(TCIS_OFF_IRQ_FLAGS, 8'h08);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h00);
  endtask : t_reset
  task automatic t_enables;
    wr(TCIS_OFF_IRQ_ENABLE_SET, 8'h3b);
    rdr(TCIS_OFF_IRQ_ENABLE_SET);
    chk(rd, 8'h3b);
    rdr(TCIS_OFF_IRQ_ENABLE_CLEAR);
    chk(rd, 8'h3b);
    wr(TCIS_OFF_IRQ_ENABLE_CLEAR, 8'h01);
    wr(TCIS_OFF_IRQ_ENABLE_CLEAR, 8'h00);
    rdr(TCIS_OFF_IRQ_ENABLE_SET);
    chk(rd, 8'h3a);
    wr(TCIS_OFF_IRQ_ENABLE_CLEAR, 8'h3b);
  endtask : t_enables
  task automatic t_match;
    @(posedge mclk);
    channelMatch <= 2'b10;
    @(posedge mclk);
    channelMatch <= 2'b00;
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h20);
    chk({7'h00, irqRequest}, 8'h00);
    wr(TCIS_OFF_IRQ_ENABLE_SET, 8'h20);
    #1;
    chk({7'h00, irqRequest}, 8'h01);
    wr(TCIS_OFF_IRQ_FLAGS, 8'h00);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h20);
    wr(TCIS_OFF_IRQ_FLAGS, 8'h20);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h00);
    chk({7'h00, irqRequest}, 8'h00);
  endtask : t_match
  // A second capture while the channel flag is still up has nowhere to go.
  task automatic t_capture;
    wr(TCIS_OFF_CONTROL, 8'h10);
    @(posedge mclk);
    channelCapture <= 2'b01;
    @(posedge mclk);
    channelCapture <= 2'b00;
    @(posedge mclk);
    channelCapture <= 2'b01;
    @(posedge mclk);
    channelCapture <= 2'b00;
    idle(6);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h1a);
    rdr(TCIS_OFF_CAPTURE0);
    chk(rd, 8'ha5);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h0a);
    wr(TCIS_OFF_IRQ_FLAGS, 8'h0a);
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h00);
  endtask : t_capture
  task automatic t_wrap;
    int i;
    wr(TCIS_OFF_IRQ_ENABLE_SET, 8'h01);
    wr(TCIS_OFF_CONTROL, 8'h03);
    i = 0;
    while (irqRequest !== 1'b1 && i < 400) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (i >= 400) begin
      n_fail++;
      report_and_stop();
    end
    rdr(TCIS_OFF_IRQ_FLAGS);
    chk(rd, 8'h01);
    idle(4);
    rdr(TCIS_OFF_UNIT_STATUS);
    chk(rd, 8'h08);
    wr(TCIS_OFF_IRQ_FLAGS, 8'h01);
    #1;
    chk({7'h00, irqRequest}, 8'h00);
    // The unit is stopped now, so a written count must stay put.
    wr(TCIS_OFF_COUNTER_VALUE, 8'h5a);
    rdr(TCIS_OFF_COUNTER_VALUE);
    chk(rd, 8'h5a);
  endtask : t_wrap
  // With the clock enable low a write must leave no trace.
  task automatic t_freeze;
    @(posedge mclk);
    clkEn <= 1'b0;
    wr(TCIS_OFF_IRQ_ENABLE_SET, 8'h02);
    @(posedge mclk);
    clkEn <= 1'b1;
    rdr(TCIS_OFF_IRQ_ENABLE_SET);
    chk(rd, 8'h21);
  endtask : t_freeze
  task automatic t_slave;
    @(posedge mclk);
    partnerMaster32 <= 1'b1;
    idle(4);
    rdr(TCIS_OFF_UNIT_STATUS);
    chk(rd, 8'h18);
  endtask : t_slave
  // ==========================================================================
  // Clock, reset and main sequence
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    n_fail = 0;
    checks = 0;
    resetn = 1'b0;
    clkEn = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    channelMatch = 2'b00;
    channelCapture = 2'b00;
    capture0 = 8'ha5;
    capture1 = 8'h5a;
    partnerMaster32 = 1'b0;
    idle(8);
    @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_enables();
    t_match();
    t_capture();
    t_wrap();
    t_freeze();
    t_slave();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
